//--- two_wire_pkg.sv
// Shared constants and carriers for the two-wire slave transmitter.
// Assumes a 250 MHz system clock and an AXI4-Lite register bus.
package two_wire_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] OFS_OWN  = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_DATA = 4'hc;

  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ZERO8    = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status codes, prescaler bits always zero
  localparam logic [7:0] ST_SLA_R     = 8'ha8;
  localparam logic [7:0] ST_ARB_SLA_R = 8'hb0;
  localparam logic [7:0] ST_DATA_ACK  = 8'hb8;
  localparam logic [7:0] ST_DATA_NACK = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK  = 8'hc8;
  localparam logic [7:0] ST_NO_INFO   = 8'hf8;
  localparam logic [7:0] ST_BUS_ERR   = 8'h00;
  localparam logic [7:0] ST_START     = 8'h08;

  localparam logic [6:0] BROADCAST_ADDR = 7'h00;

  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Hold time of a generated START condition
  localparam int CLK_NS         = 4;
  localparam int START_HOLD_NS  = 4000;
  localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [10:0] HOLD_ZERO = 11'h000;
  localparam logic [10:0] HOLD_ONE  = 11'h001;
  localparam logic [10:0] HOLD_LAST = 11'(START_HOLD_CYC - 1);

  typedef enum logic [3:0] {
    S_IDLE      = 4'h0,
    S_ADDR      = 4'h1,
    S_ADDR_ACK  = 4'h2,
    S_TX_WAIT   = 4'h3,
    S_TX        = 4'h4,
    S_TX_ACK    = 4'h5,
    S_DONE_WAIT = 4'h6,
    S_IGNORE    = 4'h7,
    S_RX        = 4'h8,
    S_ERR_WAIT  = 4'h9,
    S_BEGIN     = 4'ha,
    S_BEGIN_HLD = 4'hb
  } link_e;

  typedef struct packed {
    logic service_flag;
    logic acknowledge_enable;
    logic begin_condition_request;
    logic halt_condition_request;
    logic write_collision_flag;
    logic interface_enable;
    logic reserved;
    logic interrupt_enable;
  } ctrl_s;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_evt_s;

endpackage : two_wire_pkg

//--- line_sampler.sv
// Two-stage synchroniser and condition detector for the bus lines.
// Assumes idle-high open-drain lines sampled on aclk.
module line_sampler (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output two_wire_pkg::bus_evt_s  evt
);

  logic [1:0] meta_d, meta_q;
  logic [1:0] sync_d, sync_q;
  logic [1:0] prev_d, prev_q;

  always_comb begin
    meta_d = ce ? {scl_i, sda_i} : meta_q;
    sync_d = ce ? meta_q : sync_q;
    prev_d = ce ? sync_q : prev_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Only the second stage and its delayed copy feed any logic
  always_comb begin
    evt.scl      = sync_q[1];
    evt.sda      = sync_q[0];
    evt.scl_rise = sync_q[1] & ~prev_q[1];
    evt.scl_fall = ~sync_q[1] & prev_q[1];
    evt.start    = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
    evt.stop     = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];
  end

endmodule : line_sampler

//--- two_wire_slave_transmitter.sv
// Slave-transmitter part of a two-wire serial unit with AXI4-Lite regs.
// Assumes pins are open drain with external pull-ups, tested by the bench.
// Behaviour
// - Answer own seven-bit address; broadcast when enabled
// - Read bit selects transmit, else receive mode
// - Own address read acknowledged gives flag, 0xA8
// - After lost arbitration, read address gives 0xB0
// - Data byte acknowledged, more expected, gives 0xB8
// - Loaded byte sent after flag clear; last if
// - Data byte not acknowledged gives flag, 0xC0
// - Last byte acknowledged anyway gives flag, 0xC8
// - Clearing in 0xC0/0xC8 returns to not addressed
// - Begin request then issues START when bus free
// - Acknowledge cleared midway makes next byte last
// - After last byte ignore master, data released
// - Acknowledge off ignores address, keeps monitoring bus
// - Deep sleep recognition wakes on any own address hit; clock held low only for a read address
// - Data register not refreshed from bus
// - Flag clear means status reads 0xF8
// - Illegal START/STOP gives 0x00; halt recovers silently
//
// Chosen here: register access over AXI4-Lite and the register addresses.
module two_wire_slave_transmitter (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        deep_sleep,
  input  wire logic        arb_lost,
  output logic             wake,
  output logic             tx_mode,
  output logic             rx_mode
);

  two_wire_pkg::bus_evt_s evt;

  line_sampler u_lines (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .evt     (evt)
  );

  // AXI4-Lite slave
  logic        awready_d, awready_q, bvalid_d, bvalid_q;
  logic        arready_d, arready_q, rvalid_d, rvalid_q;
  logic [1:0]  bresp_d, bresp_q, rresp_d, rresp_q;
  logic [31:0] rdata_d, rdata_q;
  logic        wr_take, rd_take, sw_wr;

  logic [7:0]          own_d, own_q, stat_d, stat_q, data_d, data_q;
  two_wire_pkg::ctrl_s ctrl_d, ctrl_q, wr_c;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == two_wire_pkg::OFS_OWN) || (a == two_wire_pkg::OFS_CTRL)
          || (a == two_wire_pkg::OFS_STAT) || (a == two_wire_pkg::OFS_DATA);
  endfunction : mapped

  always_comb begin
    wr_take   = awready_q & awvalid & wvalid;
    rd_take   = arready_q & arvalid;
    sw_wr     = wr_take & wstrb[0];
    awready_d = awvalid & wvalid & ~awready_q & ~bvalid_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (wr_take) begin
      bvalid_d = 1'b1;
      bresp_d  = mapped(awaddr) ? two_wire_pkg::RESP_OKAY
                                : two_wire_pkg::RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    arready_d = arvalid & ~arready_q & ~rvalid_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (rd_take) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(araddr) ? two_wire_pkg::RESP_OKAY
                                : two_wire_pkg::RESP_SLVERR;
      case (araddr)
        two_wire_pkg::OFS_OWN:  rdata_d = {24'h000000, own_q};
        two_wire_pkg::OFS_CTRL: rdata_d = {24'h000000, ctrl_q};
        // Prescaler bits are zero in every code
        two_wire_pkg::OFS_STAT: rdata_d = {24'h000000,
          ctrl_q.service_flag ? stat_q : two_wire_pkg::ST_NO_INFO};
        two_wire_pkg::OFS_DATA: rdata_d = {24'h000000, data_q};
        default:                rdata_d = 32'h00000000;
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= two_wire_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= two_wire_pkg::RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else if (ce) begin
      awready_q <= awready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Link engine and registers
  two_wire_pkg::link_e state_d, state_q;
  logic [3:0]  cnt_d, cnt_q;
  logic [7:0]  sh_d, sh_q;
  logic [10:0] hold_d, hold_q;
  logic last_d, last_q, ack_d, ack_q, pend_d, pend_q, busy_d, busy_q;
  logic sda_oe_d, sda_oe_q, scl_oe_d, scl_oe_q, wake_d, wake_q;
  logic tx_d, tx_q, rx_d, rx_q;
  logic clr, hw_set, err_cond, hit;

  always_comb begin
    wr_c     = two_wire_pkg::ctrl_s'(wdata[7:0]);
    clr      = sw_wr && (awaddr == two_wire_pkg::OFS_CTRL) && wr_c.service_flag;
    own_d    = own_q;
    ctrl_d   = ctrl_q;
    data_d   = data_q;
    stat_d   = stat_q;
    hw_set   = 1'b0;
    state_d  = state_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    hold_d   = hold_q;
    last_d   = last_q;
    ack_d    = ack_q;
    pend_d   = pend_q;
    sda_oe_d = sda_oe_q;
    wake_d   = wake_q && !clr;
    busy_d   = (busy_q || evt.start) && !evt.stop;
    if (sw_wr) begin
      case (awaddr)
        two_wire_pkg::OFS_OWN: own_d = wdata[7:0];
        two_wire_pkg::OFS_CTRL: begin
          ctrl_d = wr_c;
          ctrl_d.service_flag         = ctrl_q.service_flag;
          ctrl_d.write_collision_flag = ctrl_q.write_collision_flag;
          ctrl_d.reserved             = 1'b0;
        end
        // Only software fills the data register
        two_wire_pkg::OFS_DATA: begin
          ctrl_d.write_collision_flag = !ctrl_q.service_flag;
          if (ctrl_q.service_flag) begin
            data_d = wdata[7:0];
          end
        end
        default: ;
      endcase
    end
    err_cond = (evt.start || evt.stop) &&
               ((state_q == two_wire_pkg::S_TX) ||
                (state_q == two_wire_pkg::S_TX_ACK) ||
                (state_q == two_wire_pkg::S_ADDR_ACK) ||
                ((state_q == two_wire_pkg::S_ADDR) &&
                 (cnt_q != two_wire_pkg::CNT_ZERO)));
    hit = ctrl_q.interface_enable && ctrl_q.acknowledge_enable &&
          ((sh_q[7:1] == own_q[7:1]) ||
           ((sh_q[7:1] == two_wire_pkg::BROADCAST_ADDR) && own_q[0] &&
            !sh_q[0]));
    if (!ctrl_q.interface_enable) begin
      state_d  = two_wire_pkg::S_IDLE;
      sda_oe_d = 1'b0;
    end else if (err_cond) begin
      // Both lines let go at once
      state_d  = two_wire_pkg::S_ERR_WAIT;
      sda_oe_d = 1'b0;
      hw_set   = 1'b1;
      stat_d   = two_wire_pkg::ST_BUS_ERR;
    end else begin
      case (state_q)
        two_wire_pkg::S_IDLE, two_wire_pkg::S_IGNORE, two_wire_pkg::S_RX: begin
          // Bus watched even while not answering
          if (evt.start) begin
            state_d = two_wire_pkg::S_ADDR;
            cnt_d   = two_wire_pkg::CNT_ZERO;
          end else if (evt.stop) begin
            state_d = two_wire_pkg::S_IDLE;
          end else if (state_q == two_wire_pkg::S_IDLE && pend_q && !busy_q) begin
            state_d  = two_wire_pkg::S_BEGIN;
            hold_d   = two_wire_pkg::HOLD_ZERO;
            sda_oe_d = 1'b1;
          end
        end
        two_wire_pkg::S_ADDR: begin
          if (evt.start) begin
            cnt_d = two_wire_pkg::CNT_ZERO;
          end else if (evt.stop) begin
            state_d = two_wire_pkg::S_IDLE;
          end else if (evt.scl_rise && cnt_q != two_wire_pkg::BYTE_BITS) begin
            sh_d  = {sh_q[6:0], evt.sda};
            cnt_d = cnt_q + two_wire_pkg::CNT_ONE;
          end else if (evt.scl_fall && cnt_q == two_wire_pkg::BYTE_BITS) begin
            if (hit) begin
              state_d  = two_wire_pkg::S_ADDR_ACK;
              sda_oe_d = 1'b1;
              wake_d   = wake_d || deep_sleep;
            end else begin
              state_d = two_wire_pkg::S_IGNORE;
            end
          end
        end
        two_wire_pkg::S_ADDR_ACK: begin
          if (evt.scl_fall) begin
            sda_oe_d = 1'b0;
            hw_set   = sh_q[0];
            if (sh_q[0]) begin
              state_d = two_wire_pkg::S_TX_WAIT;
              stat_d  = arb_lost ? two_wire_pkg::ST_ARB_SLA_R
                                 : two_wire_pkg::ST_SLA_R;
            end else begin
              state_d = two_wire_pkg::S_RX;
            end
          end
        end
        two_wire_pkg::S_TX_WAIT: begin
          if (clr) begin
            state_d  = two_wire_pkg::S_TX;
            sh_d     = data_q;
            sda_oe_d = !data_q[7];
            cnt_d    = two_wire_pkg::CNT_ZERO;
            last_d   = !ctrl_d.acknowledge_enable;
          end
        end
        two_wire_pkg::S_TX: begin
          if (evt.scl_fall) begin
            if (cnt_q == two_wire_pkg::LAST_BIT) begin
              state_d  = two_wire_pkg::S_TX_ACK;
              sda_oe_d = 1'b0;
            end else begin
              cnt_d    = cnt_q + two_wire_pkg::CNT_ONE;
              sh_d     = {sh_q[6:0], 1'b0};
              sda_oe_d = !sh_q[6];
            end
          end
        end
        two_wire_pkg::S_TX_ACK: begin
          if (evt.scl_rise) begin
            ack_d = !evt.sda;
          end else if (evt.scl_fall) begin
            hw_set = 1'b1;
            if (!ack_q) begin
              state_d = two_wire_pkg::S_DONE_WAIT;
              stat_d  = two_wire_pkg::ST_DATA_NACK;
            end else if (last_q) begin
              state_d = two_wire_pkg::S_DONE_WAIT;
              stat_d  = two_wire_pkg::ST_LAST_ACK;
            end else begin
              state_d = two_wire_pkg::S_TX_WAIT;
              stat_d  = two_wire_pkg::ST_DATA_ACK;
            end
          end
        end
        two_wire_pkg::S_DONE_WAIT: begin
          if (clr) begin
            state_d = two_wire_pkg::S_IGNORE;
            pend_d  = ctrl_d.begin_condition_request;
          end
        end
        two_wire_pkg::S_ERR_WAIT: begin
          if (clr && wr_c.halt_condition_request) begin
            state_d = two_wire_pkg::S_IDLE;
            ctrl_d.halt_condition_request = 1'b0;
          end
        end
        two_wire_pkg::S_BEGIN: begin
          hold_d = hold_q + two_wire_pkg::HOLD_ONE;
          if (hold_q == two_wire_pkg::HOLD_LAST) begin
            state_d = two_wire_pkg::S_BEGIN_HLD;
            pend_d  = 1'b0;
            hw_set  = 1'b1;
            stat_d  = two_wire_pkg::ST_START;
          end
        end
        two_wire_pkg::S_BEGIN_HLD: begin
          if (clr) begin
            state_d  = two_wire_pkg::S_IDLE;
            sda_oe_d = 1'b0;
          end
        end
        default: state_d = two_wire_pkg::S_IDLE;
      endcase
    end
    // A hardware set in the clearing cycle wins
    ctrl_d.service_flag = hw_set || (ctrl_q.service_flag && !clr);
    // Clock held low while software owes an answer, except after a bus error
    scl_oe_d = (state_d == two_wire_pkg::S_TX_WAIT) ||
               (state_d == two_wire_pkg::S_DONE_WAIT) ||
               (state_d == two_wire_pkg::S_BEGIN_HLD);
    tx_d = (state_d == two_wire_pkg::S_TX_WAIT) || (state_d == two_wire_pkg::S_TX)
        || (state_d == two_wire_pkg::S_TX_ACK)
        || (state_d == two_wire_pkg::S_DONE_WAIT);
    rx_d = (state_d == two_wire_pkg::S_RX);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_q    <= two_wire_pkg::OWN_RST;
      ctrl_q   <= two_wire_pkg::ctrl_s'(two_wire_pkg::CTRL_RST);
      data_q   <= two_wire_pkg::DATA_RST;
      stat_q   <= two_wire_pkg::ST_NO_INFO;
      state_q  <= two_wire_pkg::S_IDLE;
      cnt_q    <= two_wire_pkg::CNT_ZERO;
      sh_q     <= two_wire_pkg::ZERO8;
      hold_q   <= two_wire_pkg::HOLD_ZERO;
      {last_q, ack_q, pend_q, busy_q} <= 4'h0;
      {sda_oe_q, scl_oe_q, wake_q, tx_q, rx_q} <= 5'h00;
    end else if (ce) begin
      own_q    <= own_d;
      ctrl_q   <= ctrl_d;
      data_q   <= data_d;
      stat_q   <= stat_d;
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      hold_q   <= hold_d;
      {last_q, ack_q, pend_q, busy_q} <= {last_d, ack_d, pend_d, busy_d};
      {sda_oe_q, scl_oe_q, wake_q, tx_q, rx_q} <=
        {sda_oe_d, scl_oe_d, wake_d, tx_d, rx_d};
    end
  end

  // Lines only ever pulled low; level comes from a constant flop
  logic lo_q;
  always_ff @(posedge aclk) begin
    lo_q <= 1'b0;
  end

  always_comb begin
    awready = awready_q;
    wready  = awready_q;
    bvalid  = bvalid_q;
    bresp   = bresp_q;
    arready = arready_q;
    rvalid  = rvalid_q;
    rresp   = rresp_q;
    rdata   = rdata_q;
    scl_o   = lo_q;
    sda_o   = lo_q;
    scl_oe  = scl_oe_q;
    sda_oe  = sda_oe_q;
    wake    = wake_q;
    tx_mode = tx_q;
    rx_mode = rx_q;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_flag_code(logic [7:0] code);
    ctrl_q.service_flag && (stat_q == code);
  endsequence
  sequence s_released;
    !sda_oe_q && !scl_oe_q;
  endsequence

  property p_no_info;
    rd_take && (araddr == two_wire_pkg::OFS_STAT) && !ctrl_q.service_flag
      |=> rdata_q[7:0] == two_wire_pkg::ST_NO_INFO;
  endproperty
  a_no_info: assert property (p_no_info) else $error("status not F8");

  property p_sla_r(logic arb, logic [7:0] code);
    ce && ctrl_q.interface_enable && state_q == two_wire_pkg::S_ADDR_ACK
      && evt.scl_fall && sh_q[0] && arb_lost == arb
      |=> s_flag_code(code) ##0 scl_oe_q;
  endproperty
  a_sla_r: assert property (p_sla_r(1'b0, two_wire_pkg::ST_SLA_R))
    else $error("no A8 after own read address");
  a_arb_sla_r: assert property (p_sla_r(1'b1, two_wire_pkg::ST_ARB_SLA_R))
    else $error("no B0 after lost arbitration");

  property p_byte_end(logic a, logic l, logic [7:0] code);
    ce && ctrl_q.interface_enable && state_q == two_wire_pkg::S_TX_ACK
      && evt.scl_fall && ack_q == a && (l || !a || last_q == 1'b0)
      && (!l || last_q) |=> s_flag_code(code);
  endproperty
  a_nack: assert property (p_byte_end(1'b0, 1'b0, two_wire_pkg::ST_DATA_NACK))
    else $error("no C0 after nack");
  a_last: assert property (p_byte_end(1'b1, 1'b1, two_wire_pkg::ST_LAST_ACK))
    else $error("no C8 after last byte ack");
  a_more: assert property (p_byte_end(1'b1, 1'b0, two_wire_pkg::ST_DATA_ACK))
    else $error("no B8 after data ack");

  property p_stretch;
    tx_q && ctrl_q.service_flag |-> scl_oe_q;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held");

  property p_release;
    ce && ctrl_q.interface_enable && state_q == two_wire_pkg::S_DONE_WAIT
      && clr |=> s_released ##0 !tx_q;
  endproperty
  a_release: assert property (p_release) else $error("lines not freed");

  property p_first_bit;
    ce && ctrl_q.interface_enable && state_q == two_wire_pkg::S_TX_WAIT && clr
      |=> sda_oe_q == !sh_q[7] ##0 !scl_oe_q;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("bad first bit");

  property p_deaf;
    ce && state_q == two_wire_pkg::S_ADDR && evt.scl_fall
      && cnt_q == two_wire_pkg::BYTE_BITS && !ctrl_q.acknowledge_enable
      && !err_cond |=> !sda_oe_q ##1 !sda_oe_q || !ce;
  endproperty
  a_deaf: assert property (p_deaf) else $error("acked while disabled");

  property p_bus_err;
    ce && ctrl_q.interface_enable && err_cond
      |=> s_flag_code(two_wire_pkg::ST_BUS_ERR) ##0 s_released;
  endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error missed");

endmodule : two_wire_slave_transmitter

//--- two_wire_master_model.sv
// Behavioural two-wire master receiver, bus clock period 80 ns.
// Assumes the bench resolves both open-drain wires with pull-ups.
module two_wire_master_model (
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Waits on the wire itself, so a stretching slave only slows us down
  task automatic bit_c(input logic b, output logic r);
    sda_low = ~b;
    #20 scl_low = 1'b0;
    wait (scl_w);
    #20 r = sda_w;
    #20 scl_low = 1'b1;
    #20;
  endtask : bit_c
  task automatic start_c;
    sda_low = 1'b1;
    #20 scl_low = 1'b1;
    #20;
  endtask : start_c
  task automatic stop_c;
    sda_low = 1'b1;
    #20 scl_low = 1'b0;
    wait (scl_w);
    #20 sda_low = 1'b0;
    #40;
  endtask : stop_c
  // MSB first; the ninth bit is our ACK or NACK
  task automatic xfer(input logic [7:0] tx, input logic ack,
                      output logic [7:0] rx, output logic got);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_c(tx[i], b);
      rx[i] = b;
    end
    bit_c(~ack, b);
    got = ~b;
  endtask : xfer
endmodule : two_wire_master_model

//--- two_wire_slave_transmitter_tb_top.sv
// Self-checking bench: AXI4-Lite register tasks plus a master model.
// Assumes the design's offsets and status codes from two_wire_pkg.
module two_wire_slave_transmitter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, rr;
  logic        awready, wready, bvalid, arready, rvalid, ga;
  logic        scl_o, scl_oe, sda_o, sda_oe, wake, tx_mode, rx_mode;
  logic        deep_sleep, arb_lost, m_scl, m_sda, ce;
  logic [7:0]  rb;
  logic [31:0] tbl [4] = '{32'h54445700, 32'h54045500,
                           32'h54440000, 32'h55440001};
  int          bad_count, cmp_count;
  wire scl_w = !(scl_oe || m_scl);
  wire sda_w = !(sda_oe || m_sda);
  two_wire_slave_transmitter dut (.aclk, .aresetn, .ce, .awaddr,
    .awvalid, .awready, .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w),
    .sda_o, .sda_oe, .deep_sleep, .arb_lost, .wake, .tx_mode, .rx_mode);
  two_wire_master_model m (.scl_w, .sda_w, .scl_low(m_scl),
    .sda_low(m_sda));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1;
    bready <= 1;
    do @(posedge aclk); while ({awready, wready} !== 2'b11);
    awvalid <= 0; wvalid <= 0;
    while (bvalid !== 1'b1) @(posedge aclk);
    rr = bresp;
    bready <= 0;
  endtask : wr
  task automatic rdc(input string n, input logic [3:0] a,
                     input logic [7:0] e);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rb = rdata[7:0]; rr = rresp;
    rready <= 0;
    chk(n, {24'h0, rb}, {24'h0, e});
  endtask : rdc
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // Whole run is near 14 us; allow ample margin
  initial begin
    #300000;
    bad_count++;
    wrap_up();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, deep_sleep, arb_lost} = '0;
    ce = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("own", two_wire_pkg::OFS_OWN, 8'h00);
    rdc("ctrl", two_wire_pkg::OFS_CTRL, 8'h00);
    rdc("data", two_wire_pkg::OFS_DATA, 8'h00);
    rdc("idle", two_wire_pkg::OFS_STAT, 8'hf8);
    rdc("unmapped", 4'h2, 8'h00);
    chk("resp", rr, two_wire_pkg::RESP_SLVERR);
    chk("lo", {scl_o, sda_o}, 2'b00);
    // Frozen clock enable must hold off the write handshake
    ce <= 1'b0;
    fork
      wr(two_wire_pkg::OFS_OWN, 8'h12);
      begin
        repeat (8) @(posedge aclk);
        chk("frozen", awready, 1'b0);
        ce <= 1'b1;
      end
    join
    chk("okay", rr, two_wire_pkg::RESP_OKAY);
    rdc("thawed", two_wire_pkg::OFS_OWN, 8'h12);
    wr(4'h2, 8'h00);
    chk("wresp", rr, two_wire_pkg::RESP_SLVERR);
    // Own address, control, address byte, expected ACK
    foreach (tbl[k]) begin
      wr(two_wire_pkg::OFS_OWN, tbl[k][31:24]);
      wr(two_wire_pkg::OFS_CTRL, tbl[k][23:16]);
      m.start_c();
      m.xfer(tbl[k][15:8], 1'b0, rb, ga);
      chk("addr ack", ga, tbl[k][0]);
      chk("rx mode", rx_mode, tbl[k][0]);
      m.stop_c();
    end
    wr(two_wire_pkg::OFS_OWN, 8'h54);
    m.start_c();
    m.xfer(8'h55, 1'b0, rb, ga);
    chk("own ack", ga, 1'b1);
    #40 rdc("sla", two_wire_pkg::OFS_STAT, 8'ha8);
    chk("tx mode", tx_mode, 1'b1);
    chk("stretch", scl_oe, 1'b1);
    wr(two_wire_pkg::OFS_DATA, 8'ha5);
    wr(two_wire_pkg::OFS_CTRL, 8'hc4);
    m.xfer(8'hff, 1'b1, rb, ga);
    chk("byte1", rb, 8'ha5);
    #40 rdc("ack", two_wire_pkg::OFS_STAT, 8'hb8);
    wr(two_wire_pkg::OFS_DATA, 8'h3c);
    wr(two_wire_pkg::OFS_CTRL, 8'h84);
    m.xfer(8'hff, 1'b1, rb, ga);
    chk("last", rb, 8'h3c);
    #40 rdc("last ack", two_wire_pkg::OFS_STAT, 8'hc8);
    wr(two_wire_pkg::OFS_CTRL, 8'hc4);
    chk("left", tx_mode, 1'b0);
    m.xfer(8'hff, 1'b1, rb, ga);
    chk("ones", rb, 8'hff);
    m.stop_c();
    @(posedge aclk);
    deep_sleep <= 1'b1;
    arb_lost <= 1'b1;
    m.start_c();
    m.xfer(8'h55, 1'b0, rb, ga);
    #40 rdc("arb", two_wire_pkg::OFS_STAT, 8'hb0);
    chk("wake", wake, 1'b1);
    deep_sleep <= 1'b0;
    arb_lost <= 1'b0;
    wr(two_wire_pkg::OFS_DATA, 8'h96);
    wr(two_wire_pkg::OFS_CTRL, 8'hc4);
    chk("woken", wake, 1'b0);
    m.xfer(8'hff, 1'b0, rb, ga);
    chk("byte2", rb, 8'h96);
    #40 rdc("nack", two_wire_pkg::OFS_STAT, 8'hc0);
    rdc("kept", two_wire_pkg::OFS_DATA, 8'h96);
    wr(two_wire_pkg::OFS_CTRL, 8'he4);
    m.stop_c();
    // Generated START holds the data line 1000 cycles first
    #4400 rdc("begin", two_wire_pkg::OFS_STAT, 8'h08);
    wr(two_wire_pkg::OFS_CTRL, 8'h84);
    chk("released", {scl_w, sda_w}, 2'b11);
    // STOP after one address bit is an illegal position
    #40 m.start_c();
    m.bit_c(1'b0, ga);
    m.stop_c();
    #40 rdc("bus err", two_wire_pkg::OFS_STAT, 8'h00);
    chk("err free", {scl_w, sda_w}, 2'b11);
    wr(two_wire_pkg::OFS_CTRL, 8'hd4);
    rdc("halt done", two_wire_pkg::OFS_CTRL, 8'h44);
    rdc("no info", two_wire_pkg::OFS_STAT, 8'hf8);
    wrap_up();
  end
endmodule : two_wire_slave_transmitter_tb_top
